// *** design/fastlock_timer.sv ***
`timescale 1ns/1ps
module fastlock_timer #(
  parameter int unsigned TOC_W = pll_regs_pkg::TOC_W,
  parameter int unsigned COUNT_W = pll_regs_pkg::FL_COUNT_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [TOC_W-1:0] timeout_i,
  input wire logic comp_event_i,
  output logic active_o
);

  pll_regs_pkg::fl_state_type state;
  logic [COUNT_W-1:0] remaining;
  logic timed_mode;

  assign timed_mode = (timeout_i >= pll_regs_pkg::TOC_TIMED_MIN);

  //////////////////////////////////////////////////////////////////////////////
  // a fresh divider load restarts the count in timed mode, even mid-fastlock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= pll_regs_pkg::FL_IDLE;
      remaining <= '0;
    end else if (start_i && timed_mode) begin
      state <= pll_regs_pkg::FL_RUN;
      remaining <= COUNT_W'({timeout_i, 1'b0}); // twice the code
    end else begin
      unique case (state)
        pll_regs_pkg::FL_IDLE: begin
          remaining <= '0;
        end
        pll_regs_pkg::FL_RUN: begin
          // reprogramming out of timed mode ends fastlock at once
          if (!timed_mode) begin
            state <= pll_regs_pkg::FL_IDLE;
          end else if (comp_event_i) begin
            remaining <= remaining - COUNT_W'(1);
            if (remaining == COUNT_W'(1)) begin
              state <= pll_regs_pkg::FL_IDLE; // expiry
            end
          end
        end
      endcase
    end
  end

  // registered view of the run state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= (state == pll_regs_pkg::FL_RUN) && !(comp_event_i && remaining == COUNT_W'(1)) && timed_mode;
    end
  end

endmodule // fastlock_timer

// *** design/pll_divider_pump_fastlock_regs.sv ***
`timescale 1ns/1ps
module pll_divider_pump_fastlock_regs #(
  parameter int unsigned WORD_W = pll_regs_pkg::WORD_W,
  parameter int unsigned TOC_W = pll_regs_pkg::TOC_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_latch_i,
  input wire logic comp_event_i,
  input wire logic aux_pump_active_i,
  input wire logic aux_pump_tristate_ctl_i,
  output logic aux_pump_gain_o,
  output logic [2:0] aux_pump_ma_o,
  output logic aux_prescaler_16_o,
  output logic aux_power_down_o,
  output logic aux_pll_off_o,
  output logic [pll_regs_pkg::AUX_N_W-1:0] aux_feedback_divide_o,
  output logic [pll_regs_pkg::AUX_R_W-1:0] aux_reference_divide_o,
  output logic [pll_regs_pkg::MAIN_N_W-1:0] main_feedback_divide_o,
  output logic main_divide_loaded_o,
  output logic [pll_regs_pkg::PUMP_CODE_W-1:0] main_steady_pump_gain_o,
  output logic [pll_regs_pkg::PUMP_CODE_W-1:0] main_fastlock_pump_current_o,
  output logic [TOC_W-1:0] main_fastlock_timeout_o,
  output logic [pll_regs_pkg::CSR_W-1:0] cycle_slip_reduction_o,
  output logic [pll_regs_pkg::PUMP_CODE_W-1:0] main_pump_code_o,
  output logic [pll_regs_pkg::UA_W-1:0] main_pump_ua_o,
  output logic [2:0] sample_rate_shift_o,
  output logic main_fastlock_active_o,
  output logic main_fastlock_pin_o,
  output logic main_fastlock_pin_oe_o
);

  //////////////////////////////////////////////////////////////////////////////
  // serial capture

  logic ser_clk_q;
  logic ser_latch_q;
  logic [WORD_W-1:0] shift_word;
  logic clk_rise;
  logic latch_rise;
  logic load_aux_div;
  logic load_aux_ref;
  logic load_main_fl;
  logic load_main_n;
  logic timer_active;
  logic fastlock_on;
  logic [pll_regs_pkg::PUMP_CODE_W-1:0] next_pump_code;
  logic [pll_regs_pkg::UA_W-1:0] next_pump_ua;

  // strobes are synchronous to clk_i, so plain edge detection suffices
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ser_clk_q <= 1'b0;
      ser_latch_q <= 1'b0;
    end else begin
      ser_clk_q <= ser_clk_i;
      ser_latch_q <= ser_latch_i;
    end
  end

  assign clk_rise = ser_clk_i && !ser_clk_q;
  assign latch_rise = ser_latch_i && !ser_latch_q;

  // msb first; the last bit shifted in ends up as the select lsb
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_word <= '0;
    end else if (clk_rise) begin
      shift_word <= {shift_word[WORD_W-2:0], ser_data_i};
    end
  end

  // word routing by select code; other select codes belong elsewhere
  assign load_main_n = latch_rise && !shift_word[pll_regs_pkg::MAIN_N_SEL_BIT];
  assign load_aux_div = latch_rise && (shift_word[pll_regs_pkg::SEL_W-1:0] == pll_regs_pkg::SEL_AUX_DIV);
  assign load_aux_ref = latch_rise && (shift_word[pll_regs_pkg::SEL_W-1:0] == pll_regs_pkg::SEL_AUX_REF);
  assign load_main_fl = latch_rise && (shift_word[pll_regs_pkg::SEL_W-1:0] == pll_regs_pkg::SEL_MAIN_FL);

  //////////////////////////////////////////////////////////////////////////////
  // aux divider control word

  // no ratio checks here: legality of the aux n value is the host's job
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_power_down_o <= 1'b0;
      aux_prescaler_16_o <= 1'b0;
      aux_pump_gain_o <= 1'b0;
      aux_feedback_divide_o <= '0;
    end else if (load_aux_div) begin
      aux_power_down_o <= shift_word[pll_regs_pkg::AUX_PD_BIT];
      aux_prescaler_16_o <= shift_word[pll_regs_pkg::AUX_PRESC_BIT];
      aux_pump_gain_o <= shift_word[pll_regs_pkg::AUX_GAIN_BIT];
      aux_feedback_divide_o <= shift_word[pll_regs_pkg::AUX_N_LSB +: pll_regs_pkg::AUX_N_W];
    end
  end

  // pump magnitude follows the stored gain bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_pump_ma_o <= pll_regs_pkg::AUX_PUMP_LOW_MA;
    end else begin
      aux_pump_ma_o <= aux_pump_gain_o ? pll_regs_pkg::AUX_PUMP_HIGH_MA
                                       : pll_regs_pkg::AUX_PUMP_LOW_MA;
    end
  end

  // power-down waits for an idle pump unless told to cut at once;
  // waiting avoids dumping a half pulse of charge into the loop filter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_pll_off_o <= 1'b0;
    end else if (!aux_power_down_o) begin
      aux_pll_off_o <= 1'b0;
    end else if (aux_pump_tristate_ctl_i) begin
      aux_pll_off_o <= 1'b1;
    end else if (!aux_pump_active_i) begin
      aux_pll_off_o <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // aux reference and main steady gain word

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_steady_pump_gain_o <= '0;
      aux_reference_divide_o <= '0;
    end else if (load_aux_ref) begin
      main_steady_pump_gain_o <= shift_word[pll_regs_pkg::MAIN_CPG_LSB +: pll_regs_pkg::PUMP_CODE_W];
      aux_reference_divide_o <= shift_word[pll_regs_pkg::AUX_R_LSB +: pll_regs_pkg::AUX_R_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main fastlock word and main divider

  // currents and slip setting are stored independently; matching them is up to the host
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cycle_slip_reduction_o <= '0;
      main_fastlock_pump_current_o <= '0;
      main_fastlock_timeout_o <= '0;
    end else if (load_main_fl) begin
      cycle_slip_reduction_o <= shift_word[pll_regs_pkg::CSR_LSB +: pll_regs_pkg::CSR_W];
      main_fastlock_pump_current_o <= shift_word[pll_regs_pkg::MAIN_CPF_LSB +: pll_regs_pkg::PUMP_CODE_W];
      main_fastlock_timeout_o <= shift_word[pll_regs_pkg::TOC_LSB +: TOC_W];
    end
  end

  // loading the divider is what kicks off a timed fastlock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_feedback_divide_o <= '0;
      main_divide_loaded_o <= 1'b0;
    end else begin
      main_divide_loaded_o <= load_main_n;
      if (load_main_n) begin
        main_feedback_divide_o <= shift_word[pll_regs_pkg::MAIN_N_LSB +: pll_regs_pkg::MAIN_N_W];
      end
    end
  end

  fastlock_timer #(
    .TOC_W(TOC_W),
    .COUNT_W(pll_regs_pkg::FL_COUNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(main_divide_loaded_o),
    .timeout_i(main_fastlock_timeout_o),
    .comp_event_i(comp_event_i),
    .active_o(timer_active)
  );

  //////////////////////////////////////////////////////////////////////////////
  // fastlock conditions

  // manual mode holds fastlock with no timeout at all
  assign fastlock_on = (main_fastlock_timeout_o == pll_regs_pkg::TOC_MANUAL) || timer_active;

  always_comb begin
    next_pump_code = fastlock_on ? main_fastlock_pump_current_o : main_steady_pump_gain_o;
    next_pump_ua = (pll_regs_pkg::UA_W'(next_pump_code) + pll_regs_pkg::UA_W'(1))
                   * pll_regs_pkg::PUMP_STEP_UA;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_fastlock_active_o <= 1'b0;
      main_pump_code_o <= '0;
      main_pump_ua_o <= pll_regs_pkg::PUMP_STEP_UA;
    end else begin
      main_fastlock_active_o <= fastlock_on;
      main_pump_code_o <= next_pump_code;
      main_pump_ua_o <= next_pump_ua;
    end
  end

  // slip reduction only acts while fastlock conditions are applied
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_rate_shift_o <= pll_regs_pkg::CSR_SHIFT_OFF;
    end else if (!fastlock_on) begin
      sample_rate_shift_o <= pll_regs_pkg::CSR_SHIFT_OFF;
    end else begin
      unique case (cycle_slip_reduction_o)
        2'h0: sample_rate_shift_o <= pll_regs_pkg::CSR_SHIFT_OFF;
        2'h1: sample_rate_shift_o <= pll_regs_pkg::CSR_SHIFT_HALF;
        2'h2: sample_rate_shift_o <= pll_regs_pkg::CSR_SHIFT_QUARTER;
        2'h3: sample_rate_shift_o <= pll_regs_pkg::CSR_SHIFT_SIXTEENTH;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fastlock pin

  // in timed mode the pin pulls low during fastlock and floats afterwards
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_fastlock_pin_o <= 1'b0;
      main_fastlock_pin_oe_o <= 1'b0;
    end else begin
      main_fastlock_pin_o <= 1'b0;
      if (main_fastlock_timeout_o == pll_regs_pkg::TOC_HIZ) begin
        main_fastlock_pin_oe_o <= 1'b0;
      end else if (main_fastlock_timeout_o == pll_regs_pkg::TOC_MANUAL) begin
        main_fastlock_pin_oe_o <= 1'b1;
      end else if (main_fastlock_timeout_o == pll_regs_pkg::TOC_DRIVE_LOW) begin
        main_fastlock_pin_oe_o <= 1'b1;
      end else if (main_fastlock_timeout_o == pll_regs_pkg::TOC_DRIVE_HIGH) begin
        main_fastlock_pin_o <= 1'b1;
        main_fastlock_pin_oe_o <= 1'b1;
      end else begin
        main_fastlock_pin_oe_o <= timer_active;
      end
    end
  end

endmodule // pll_divider_pump_fastlock_regs

// *** design/pll_regs_pkg.sv ***
package pll_regs_pkg;

  // serial word framing
  localparam int unsigned WORD_W = 24;
  localparam int unsigned SEL_W = 4;
  localparam logic [3:0] SEL_AUX_DIV = 4'h3;
  localparam logic [3:0] SEL_AUX_REF = 4'h5;
  localparam logic [3:0] SEL_MAIN_FL = 4'h7;
  // the main divider word is the only one whose lowest bit is zero
  localparam int unsigned MAIN_N_SEL_BIT = 0;
  localparam int unsigned MAIN_N_LSB = 1;
  localparam int unsigned MAIN_N_W = 23;

  // aux divider control word
  localparam int unsigned AUX_PD_BIT = 23;
  localparam int unsigned AUX_PRESC_BIT = 22;
  localparam int unsigned AUX_GAIN_BIT = 21;
  localparam int unsigned AUX_N_LSB = 4;
  localparam int unsigned AUX_N_W = 17;

  // aux reference and main pump gain word
  localparam int unsigned MAIN_CPG_LSB = 19;
  localparam int unsigned PUMP_CODE_W = 4;
  localparam int unsigned AUX_R_LSB = 4;
  localparam int unsigned AUX_R_W = 15;

  // main fastlock word
  localparam int unsigned CSR_LSB = 22;
  localparam int unsigned CSR_W = 2;
  localparam int unsigned MAIN_CPF_LSB = 18;
  localparam int unsigned TOC_LSB = 4;
  localparam int unsigned TOC_W = 14;

  // timeout codes
  localparam logic [13:0] TOC_HIZ = 14'h0000;
  localparam logic [13:0] TOC_MANUAL = 14'h0001;
  localparam logic [13:0] TOC_DRIVE_LOW = 14'h0002;
  localparam logic [13:0] TOC_DRIVE_HIGH = 14'h0003;
  localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
  // pump events per timeout code unit
  localparam int unsigned FL_EVENTS_PER_CODE = 2;
  localparam int unsigned FL_COUNT_W = 15;

  // pump currents
  localparam int unsigned UA_W = 11;
  localparam logic [10:0] PUMP_STEP_UA = 11'h064;
  localparam logic [2:0] AUX_PUMP_LOW_MA = 3'h1;
  localparam logic [2:0] AUX_PUMP_HIGH_MA = 3'h4;

  // log2 of the sample rate reduction for each slip code
  localparam logic [2:0] CSR_SHIFT_OFF = 3'h0;
  localparam logic [2:0] CSR_SHIFT_HALF = 3'h1;
  localparam logic [2:0] CSR_SHIFT_QUARTER = 3'h2;
  localparam logic [2:0] CSR_SHIFT_SIXTEENTH = 3'h4;

  typedef enum logic [0:0] {
    FL_IDLE = 1'b0,
    FL_RUN = 1'b1
  } fl_state_type;

endpackage

// *** verification/host_model.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// host side of the three-wire port; every change lands on a falling clk edge
module host_model (
  input wire logic clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_latch_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_latch_o = 1'b0;
  end

  // msb first, payload high and select low; each clock level held a full cycle so no rise is lost
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk_i);
      ser_clk_o = 1'b0;
      ser_data_o = word[i];
      @(negedge clk_i);
      ser_clk_o = 1'b1;
    end
    @(negedge clk_i);
    ser_clk_o = 1'b0;
    ser_latch_o = 1'b1;
    @(negedge clk_i);
    ser_latch_o = 1'b0;
    ser_data_o = ~ser_data_o; // idle data is not the last bit, so a late sample shows
  endtask
endmodule // host_model

// *** verification/pll_regs_chk.sv ***
`timescale 1ns/1ps
module pll_regs_chk #(
  parameter int unsigned TOC_W = pll_regs_pkg::TOC_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic aux_pump_active_i,
  input wire logic aux_pump_tristate_ctl_i,
  input wire logic aux_pump_gain_o,
  input wire logic [2:0] aux_pump_ma_o,
  input wire logic aux_power_down_o,
  input wire logic aux_pll_off_o,
  input wire logic main_divide_loaded_o,
  input wire logic [pll_regs_pkg::PUMP_CODE_W-1:0] main_fastlock_pump_current_o,
  input wire logic [TOC_W-1:0] main_fastlock_timeout_o,
  input wire logic [pll_regs_pkg::CSR_W-1:0] cycle_slip_reduction_o,
  input wire logic [pll_regs_pkg::PUMP_CODE_W-1:0] main_pump_code_o,
  input wire logic [pll_regs_pkg::UA_W-1:0] main_pump_ua_o,
  input wire logic [2:0] sample_rate_shift_o,
  input wire logic main_fastlock_active_o,
  input wire logic main_fastlock_pin_o,
  input wire logic main_fastlock_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////
  // derived outputs lag their fields by a cycle, hence the repeated antecedents
  ma_follow_a: assert property ($changed(aux_pump_gain_o) |=>
    aux_pump_ma_o == ($past(aux_pump_gain_o) ? 3'h4 : 3'h1))
    else $error("aux pump current does not follow gain");
  ua_map_a: assert property ((!$changed(main_pump_code_o)) [*2] |->
    main_pump_ua_o == 11'(main_pump_code_o) * 11'h064 + 11'h064)
    else $error("main pump current not code plus one hundreds");
  pin_low_a: assert property ((main_fastlock_timeout_o == 14'h0002) [*3] |->
    main_fastlock_pin_oe_o && !main_fastlock_pin_o)
    else $error("pin not driven low for code two");
  pin_high_a: assert property ((main_fastlock_timeout_o == 14'h0003) [*3] |->
    main_fastlock_pin_oe_o && main_fastlock_pin_o)
    else $error("pin not driven high for code three");
  manual_mode_a: assert property ((main_fastlock_timeout_o == 14'h0001) [*3] |->
    main_fastlock_active_o && !main_fastlock_pin_o)
    else $error("manual fastlock not applied");
  // load pulse, timer state, timer output flop, then the outputs: three edges
  fl_start_a: assert property (main_divide_loaded_o && main_fastlock_timeout_o >= 14'h0004 |->
    ##3 main_fastlock_active_o && main_fastlock_pin_oe_o)
    else $error("timed fastlock did not start after divider load");
  // the applied code is the one stored a cycle before, so a fresh word mid-fastlock is not flagged
  pump_select_a: assert property (main_fastlock_active_o [*2] |->
    main_pump_code_o == $past(main_fastlock_pump_current_o))
    else $error("fastlock pump code not applied");
  slip_shift_a: assert property (main_fastlock_active_o [*2] |->
    sample_rate_shift_o == (($past(cycle_slip_reduction_o) == 2'h3) ? 3'h4 : {1'b0, $past(cycle_slip_reduction_o)}))
    else $error("slip shift does not match slip code");
  pd_now_a: assert property (aux_power_down_o && aux_pump_tristate_ctl_i |-> ##[0:1] aux_pll_off_o)
    else $error("immediate aux power-down missing");
  pd_defer_a: assert property ($rose(aux_pll_off_o) && !aux_pump_tristate_ctl_i |-> !$past(aux_pump_active_i) && aux_power_down_o)
    else $error("aux powered down while pump active");
  cover property ($fell(main_fastlock_active_o));
  cover property ($rose(aux_pll_off_o) && !aux_pump_tristate_ctl_i);
  cover property (main_fastlock_pin_oe_o && main_fastlock_pin_o);
endmodule // pll_regs_chk

bind pll_divider_pump_fastlock_regs pll_regs_chk #(
  .TOC_W(TOC_W)
) pll_regs_chk_i (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .aux_pump_active_i(aux_pump_active_i),
  .aux_pump_tristate_ctl_i(aux_pump_tristate_ctl_i),
  .aux_pump_gain_o(aux_pump_gain_o),
  .aux_pump_ma_o(aux_pump_ma_o),
  .aux_power_down_o(aux_power_down_o),
  .aux_pll_off_o(aux_pll_off_o),
  .main_divide_loaded_o(main_divide_loaded_o),
  .main_fastlock_pump_current_o(main_fastlock_pump_current_o),
  .main_fastlock_timeout_o(main_fastlock_timeout_o),
  .cycle_slip_reduction_o(cycle_slip_reduction_o),
  .main_pump_code_o(main_pump_code_o),
  .main_pump_ua_o(main_pump_ua_o),
  .sample_rate_shift_o(sample_rate_shift_o),
  .main_fastlock_active_o(main_fastlock_active_o),
  .main_fastlock_pin_o(main_fastlock_pin_o),
  .main_fastlock_pin_oe_o(main_fastlock_pin_oe_o)
);

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic comp_event_i = 1'b0;
  logic aux_pump_active_i = 1'b0;
  logic aux_pump_tristate_ctl_i = 1'b0;
  logic ser_clk_i, ser_data_i, ser_latch_i, aux_pump_gain_o, aux_prescaler_16_o, aux_power_down_o, aux_pll_off_o;
  logic main_divide_loaded_o, main_fastlock_active_o, main_fastlock_pin_o, main_fastlock_pin_oe_o;
  logic [2:0] aux_pump_ma_o, sample_rate_shift_o;
  logic [16:0] aux_feedback_divide_o;
  logic [14:0] aux_reference_divide_o;
  logic [22:0] main_feedback_divide_o;
  logic [3:0] main_steady_pump_gain_o, main_fastlock_pump_current_o, main_pump_code_o;
  logic [13:0] main_fastlock_timeout_o;
  logic [1:0] cycle_slip_reduction_o;
  logic [10:0] main_pump_ua_o;
  int miscompares = 0;
  int num_checks = 0;

  always #12.5 clk_i = ~clk_i;

  pll_divider_pump_fastlock_regs pll_divider_pump_fastlock_regs_i (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ser_clk_i(ser_clk_i),
    .ser_data_i(ser_data_i),
    .ser_latch_i(ser_latch_i),
    .comp_event_i(comp_event_i),
    .aux_pump_active_i(aux_pump_active_i),
    .aux_pump_tristate_ctl_i(aux_pump_tristate_ctl_i),
    .aux_pump_gain_o(aux_pump_gain_o),
    .aux_pump_ma_o(aux_pump_ma_o),
    .aux_prescaler_16_o(aux_prescaler_16_o),
    .aux_power_down_o(aux_power_down_o),
    .aux_pll_off_o(aux_pll_off_o),
    .aux_feedback_divide_o(aux_feedback_divide_o),
    .aux_reference_divide_o(aux_reference_divide_o),
    .main_feedback_divide_o(main_feedback_divide_o),
    .main_divide_loaded_o(main_divide_loaded_o),
    .main_steady_pump_gain_o(main_steady_pump_gain_o),
    .main_fastlock_pump_current_o(main_fastlock_pump_current_o),
    .main_fastlock_timeout_o(main_fastlock_timeout_o),
    .cycle_slip_reduction_o(cycle_slip_reduction_o),
    .main_pump_code_o(main_pump_code_o),
    .main_pump_ua_o(main_pump_ua_o),
    .sample_rate_shift_o(sample_rate_shift_o),
    .main_fastlock_active_o(main_fastlock_active_o),
    .main_fastlock_pin_o(main_fastlock_pin_o),
    .main_fastlock_pin_oe_o(main_fastlock_pin_oe_o)
  );
  host_model host_model_i (.clk_i(clk_i), .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i), .ser_latch_o(ser_latch_i));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    num_checks++;
    if (seen !== expected) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // four cycles covers field update plus the derived outputs one further on
  task automatic send_wait(input logic [23:0] word);
    host_model_i.send(word);
    repeat (4) @(negedge clk_i);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic test_reference();
    send_wait({1'b0, 4'h0, 15'h7fff, pll_regs_pkg::SEL_AUX_REF});
    check(aux_reference_divide_o, 15'h7fff);
    check(main_pump_ua_o, 11'h064);
    send_wait({1'b0, 4'hf, 15'h0003, pll_regs_pkg::SEL_AUX_REF}); // smallest legal divider
    check(aux_reference_divide_o, 15'h0003);
    check(main_steady_pump_gain_o, 4'hf);
    check(main_pump_ua_o, 11'h0640);
    $display("reference test done");
  endtask

  // pump busy while power-down is asked: with deferral the pll must wait for idle
  task automatic test_aux_power();
    aux_pump_active_i = 1'b1;
    send_wait({3'b111, 17'h0_0030, pll_regs_pkg::SEL_AUX_DIV}); // ratio 48 with 16/17
    check(aux_power_down_o, 1'b1);
    check(aux_pll_off_o, 1'b0);
    check(aux_pump_ma_o, 3'h4);
    check(aux_pump_gain_o, 1'b1);
    check(aux_prescaler_16_o, 1'b1);
    check(aux_feedback_divide_o, 17'h0_0030);
    aux_pump_active_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check(aux_pll_off_o, 1'b1);
    send_wait({3'b000, 17'h0_0070, pll_regs_pkg::SEL_AUX_DIV}); // ratio 112 with 8/9
    check(aux_pll_off_o, 1'b0);
    check(aux_pump_ma_o, 3'h1);
    check(aux_prescaler_16_o, 1'b0);
    aux_pump_tristate_ctl_i = 1'b1;
    aux_pump_active_i = 1'b1;
    send_wait({3'b100, 17'h0_0070, pll_regs_pkg::SEL_AUX_DIV});
    check(aux_pll_off_o, 1'b1);
    $display("aux power test done");
  endtask

  task automatic test_pin_modes();
    for (int k = 0; k < 4; k++) begin
      send_wait({2'h0, 4'h9, 14'(k), pll_regs_pkg::SEL_MAIN_FL});
      check(main_fastlock_timeout_o, 14'(k));
      check(main_fastlock_pin_oe_o, k != 0);
      check(main_fastlock_pin_o, k == 3);
      check(main_fastlock_active_o, k == 1);
      check(main_pump_code_o, (k == 1) ? 4'h9 : 4'hf);
    end
    $display("pin mode test done");
  endtask

  // manual fastlock keeps the slip reduction applied, so every code is visible
  task automatic test_slip();
    for (int c = 0; c < 4; c++) begin
      send_wait({2'(c), 4'h2, 14'h0001, pll_regs_pkg::SEL_MAIN_FL});
      check(sample_rate_shift_o, (c == 3) ? 3'h4 : 3'(c));
    end
    $display("slip test done");
  endtask

  // smallest timed code: exactly eight events, spaced two cycles apart
  task automatic test_timed();
    send_wait({2'h3, 4'h5, 14'h0004, pll_regs_pkg::SEL_MAIN_FL}); // currents and slip picked as a set
    check(main_fastlock_pump_current_o, 4'h5);
    check(cycle_slip_reduction_o, 2'h3);
    check(main_fastlock_active_o, 1'b0);
    check(main_fastlock_pin_oe_o, 1'b0);
    // the load pulse stands only in the cycle after the latch, so look as the send returns
    host_model_i.send({23'h00_1234, 1'b0});
    check(main_divide_loaded_o, 1'b1);
    repeat (4) @(negedge clk_i);
    check(main_feedback_divide_o, 23'h00_1234);
    check(main_pump_ua_o, 11'h0258);
    check(sample_rate_shift_o, 3'h4);
    for (int e = 1; e <= 8; e++) begin
      check(main_fastlock_active_o, 1'b1);
      comp_event_i = 1'b1;
      @(negedge clk_i);
      comp_event_i = 1'b0;
      @(negedge clk_i);
    end
    repeat (2) @(negedge clk_i);
    check(main_fastlock_active_o, 1'b0);
    check(main_pump_code_o, 4'hf);
    check(main_fastlock_pin_oe_o, 1'b0);
    $display("timed fastlock test done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    check(aux_pump_ma_o, 3'h1);
    check(main_pump_ua_o, 11'h064);
    check(main_fastlock_pin_oe_o, 1'b0);
    test_reference();
    test_aux_power();
    test_pin_modes();
    test_slip();
    test_timed();
    complete_run();
  end

  // fifteen words of about fifty cycles each; five thousand leaves wide margin
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
endmodule // testbench
